// ==== hw/nvsc_pkg.sv ====
// Package of constants and carrier types for the host-side store/recall controller.
// What this block does
// - Host holds store/busy low at least 15 ns.
// - Six reads ending 0FC0 start store.
// - Same five reads then 0C63 start recall.
// - Write enable stays high for all six.
// - Space sequence reads at least 55 ns.
// - Address stable through whole write cycle.
// - Output enable held high during writes.
// - Inserted access aborts the six-read sequence.
package nvsc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_STORE_MS = 10;
    localparam int T_RESTORE_US = 550;
    localparam int T_RECALL_US = 20;
    localparam int T_RECOVER_NS = 700;
    localparam int T_HSB_PULSE_NS = 15;
    localparam int T_BUSY_NS = 300;
    localparam int T_SEQ_CYCLE_NS = 55;
    localparam int STORE_CYC = T_STORE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESTORE_CYC = T_RESTORE_US * 1000 / CLK_PERIOD_NS;
    localparam int RECALL_CYC = T_RECALL_US * 1000 / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = T_RECOVER_NS / CLK_PERIOD_NS;
    localparam int HSB_PULSE_CYC = (T_HSB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CYC = T_BUSY_NS / CLK_PERIOD_NS;
    // Half of one sequence read; two halves must cover the cycle time.
    localparam int SEQ_HALF_CYC = (T_SEQ_CYCLE_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    // Pin inputs reach the stable output four edges after they change.
    localparam int SYNC_LAG_CYC = 4;
    localparam int READ_HOLD_CYC = 2 + SYNC_LAG_CYC;
    localparam int WRITE_PULSE_CYC = 1;
    localparam int SENSE_CYC = BUSY_CYC + SYNC_LAG_CYC + 1;
    localparam int CNT_W = 18;

    // ----------------------------------------------------------------
    // Memory geometry and software sequence addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_LEN = 6;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_0 = 15'h0e38;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_1 = 15'h31c7;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_2 = 15'h03e0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_3 = 15'h3c1f;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_4 = 15'h303f;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_STORE = 15'h0fc0;
    localparam logic [ADDR_W-1:0] SEQ_ADDR_RECALL = 15'h0c63;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        NVSC_OP_READ,
        NVSC_OP_WRITE,
        NVSC_OP_HW_STORE,
        NVSC_OP_SW_STORE,
        NVSC_OP_SW_RECALL
    } nvsc_op_type;

    typedef struct packed {
        nvsc_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } nvsc_req_type;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] address_in;
        logic [DATA_W-1:0] data_o;
        logic data_oe;
        logic hw_store_busy_n_o;
        logic hw_store_busy_n_oe;
    } nvsc_pins_out_type;

    typedef struct packed {
        logic [DATA_W-1:0] data_i;
        logic hw_store_busy_n_i;
    } nvsc_pins_in_type;

    localparam nvsc_pins_out_type PINS_IDLE = '{
        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, address_in: '0, data_o: '0,
        data_oe: 1'b0, hw_store_busy_n_o: 1'b0, hw_store_busy_n_oe: 1'b0
    };

endpackage

// ==== hw/nvsc_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
module nvsc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] stable;
    } nvsc_sync_state_type;

    nvsc_sync_state_type st_ff;
    nvsc_sync_state_type nxt_st;

    // The first stage feeds only the second; the filter looks at stages two and three.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.stable = (st_ff.s2 & st_ff.s3) | (st_ff.stable & (st_ff.s2 ^ st_ff.s3));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, stable: RESET_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stable;

endmodule

// ==== hw/nvsc_host.sv ====
// Host controller that drives the nonvolatile static memory through its pins.
`timescale 1ns/100ps
module nvsc_host #(
    parameter int STORE_CYC = nvsc_pkg::STORE_CYC,
    parameter int RESTORE_CYC = nvsc_pkg::RESTORE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire nvsc_pkg::nvsc_req_type req,
    output logic req_ready,
    output logic done,
    output logic [nvsc_pkg::DATA_W-1:0] rdata,
    output logic nv_busy,
    output logic dirty,
    output logic store_skipped,
    output nvsc_pkg::nvsc_pins_out_type pins_out,
    input wire nvsc_pkg::nvsc_pins_in_type pins_in
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        NVSC_POWERUP,
        NVSC_IDLE,
        NVSC_READ,
        NVSC_WRITE,
        NVSC_WRITE_END,
        NVSC_SEQ_SETUP,
        NVSC_SEQ_LOW,
        NVSC_NV_WAIT,
        NVSC_HSB_PULSE,
        NVSC_HSB_SENSE,
        NVSC_HSB_WAIT,
        NVSC_RECOVER
    } nvsc_state_type;

    typedef struct packed {
        nvsc_state_type st;
        logic [nvsc_pkg::CNT_W-1:0] cnt;
        logic [2:0] step;
        logic is_store;
        logic [nvsc_pkg::DATA_W-1:0] rdata;
        logic dirty;
        logic ready;
        logic done;
        logic nv_busy;
        logic skipped;
        nvsc_pkg::nvsc_pins_out_type pins;
    } nvsc_host_state_type;

    localparam nvsc_host_state_type RESET_STATE = '{
        st: NVSC_POWERUP, cnt: '0, step: '0, is_store: 1'b0, rdata: '0, dirty: 1'b0,
        ready: 1'b0, done: 1'b0, nv_busy: 1'b1, skipped: 1'b0, pins: nvsc_pkg::PINS_IDLE
    };

    nvsc_host_state_type st_ff;
    nvsc_host_state_type nxt_st;
    logic [nvsc_pkg::DATA_W-1:0] data_s;
    logic hsb_s;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    nvsc_sync #(.WIDTH(nvsc_pkg::DATA_W), .RESET_VAL('0)) u_sync_data (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pins_in.data_i),
        .sync_out(data_s)
    );

    nvsc_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_hsb (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(pins_in.hw_store_busy_n_i),
        .sync_out(hsb_s)
    );

    // The five common steps, then the last address chosen by the operation.
    function automatic logic [nvsc_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] step, input logic store);
        logic [nvsc_pkg::ADDR_W-1:0] a;
        a = nvsc_pkg::SEQ_ADDR_0;
        unique case (step)
            3'h0: a = nvsc_pkg::SEQ_ADDR_0;
            3'h1: a = nvsc_pkg::SEQ_ADDR_1;
            3'h2: a = nvsc_pkg::SEQ_ADDR_2;
            3'h3: a = nvsc_pkg::SEQ_ADDR_3;
            3'h4: a = nvsc_pkg::SEQ_ADDR_4;
            default: a = store ? nvsc_pkg::SEQ_ADDR_STORE : nvsc_pkg::SEQ_ADDR_RECALL;
        endcase
        // The device ignores the top bit; keep it low so the pattern is exact.
        a[nvsc_pkg::ADDR_W-1] = 1'b0;
        return a;
    endfunction

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.ready = 1'b0;
        if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        unique case (st_ff.st)
            NVSC_POWERUP: begin
                // Nothing is issued until the power-up recall has surely finished.
                if (st_ff.cnt == '0 && hsb_s) begin
                    nxt_st.st = NVSC_IDLE;
                    nxt_st.ready = 1'b1;
                    nxt_st.nv_busy = 1'b0;
                end
            end
            NVSC_IDLE: begin
                nxt_st.ready = 1'b1;
                nxt_st.pins = nvsc_pkg::PINS_IDLE;
                if (!hsb_s) begin
                    // The device pulled the pin on supply loss; keep off the bus.
                    nxt_st.st = NVSC_HSB_WAIT;
                    nxt_st.ready = 1'b0;
                    nxt_st.nv_busy = 1'b1;
                    nxt_st.step = 3'h7;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(STORE_CYC);
                end else if (req_valid) begin
                    nxt_st.ready = 1'b0;
                    nxt_st.skipped = 1'b0;
                    nxt_st.pins.address_in = req.addr;
                    unique case (req.op)
                        nvsc_pkg::NVSC_OP_READ: begin
                            nxt_st.st = NVSC_READ;
                            nxt_st.pins.ce_n = 1'b0;
                            nxt_st.pins.oe_n = 1'b0;
                            nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::READ_HOLD_CYC - 1);
                        end
                        nvsc_pkg::NVSC_OP_WRITE: begin
                            nxt_st.st = NVSC_WRITE;
                            nxt_st.pins.ce_n = 1'b0;
                            nxt_st.pins.we_n = 1'b0;
                            nxt_st.pins.oe_n = 1'b1;
                            nxt_st.pins.data_o = req.wdata;
                            nxt_st.pins.data_oe = 1'b1;
                            nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::WRITE_PULSE_CYC - 1);
                        end
                        nvsc_pkg::NVSC_OP_HW_STORE: begin
                            nxt_st.st = NVSC_HSB_PULSE;
                            nxt_st.nv_busy = 1'b1;
                            nxt_st.pins.hw_store_busy_n_oe = 1'b1;
                            nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::HSB_PULSE_CYC - 1);
                        end
                        default: begin
                            // Store and recall share the sequence; it always starts at step 0.
                            nxt_st.st = NVSC_SEQ_SETUP;
                            nxt_st.nv_busy = 1'b1;
                            nxt_st.step = 3'h0;
                            nxt_st.is_store = (req.op == nvsc_pkg::NVSC_OP_SW_STORE);
                            nxt_st.pins.address_in = seq_addr(3'h0, 1'b0);
                            nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::SEQ_HALF_CYC - 1);
                        end
                    endcase
                end
            end
            NVSC_READ: begin
                // Strobes stay low long enough for data to cross the synchroniser.
                if (st_ff.cnt == '0) begin
                    nxt_st.rdata = data_s;
                    nxt_st.pins = nvsc_pkg::PINS_IDLE;
                    nxt_st.pins.address_in = st_ff.pins.address_in;
                    nxt_st.st = NVSC_IDLE;
                    nxt_st.done = 1'b1;
                    nxt_st.ready = 1'b1;
                end
            end
            NVSC_WRITE: begin
                if (st_ff.cnt == '0) begin
                    // Both enables rise together; address and data hold one more cycle.
                    nxt_st.pins.we_n = 1'b1;
                    nxt_st.pins.ce_n = 1'b1;
                    nxt_st.st = NVSC_WRITE_END;
                end
            end
            NVSC_WRITE_END: begin
                nxt_st.pins = nvsc_pkg::PINS_IDLE;
                nxt_st.pins.address_in = st_ff.pins.address_in;
                nxt_st.dirty = 1'b1;
                nxt_st.st = NVSC_IDLE;
                nxt_st.done = 1'b1;
                nxt_st.ready = 1'b1;
            end
            NVSC_SEQ_SETUP: begin
                // Address settles with chip enable high, so each fall counts once.
                if (st_ff.cnt == '0) begin
                    nxt_st.pins.ce_n = 1'b0;
                    nxt_st.st = NVSC_SEQ_LOW;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::SEQ_HALF_CYC - 1);
                end
            end
            NVSC_SEQ_LOW: begin
                // Write and output enable stay high; no other access is interleaved.
                nxt_st.pins.we_n = 1'b1;
                if (st_ff.cnt == '0) begin
                    nxt_st.pins.ce_n = 1'b1;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::SEQ_HALF_CYC - 1);
                    if (st_ff.step == 3'(nvsc_pkg::SEQ_LEN - 1)) begin
                        nxt_st.st = NVSC_NV_WAIT;
                        nxt_st.cnt = st_ff.is_store ? nvsc_pkg::CNT_W'(STORE_CYC)
                                                    : nvsc_pkg::CNT_W'(nvsc_pkg::RECALL_CYC);
                    end else begin
                        nxt_st.step = st_ff.step + 3'h1;
                        nxt_st.pins.address_in = seq_addr(st_ff.step + 3'h1, st_ff.is_store);
                        nxt_st.st = NVSC_SEQ_SETUP;
                    end
                end
            end
            NVSC_NV_WAIT: begin
                // A software store runs whether or not anything was written.
                if (st_ff.cnt == '0 && hsb_s) begin
                    nxt_st.dirty = 1'b0;
                    nxt_st.step = 3'h0;
                    nxt_st.st = NVSC_RECOVER;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::RECOVER_CYC);
                end
            end
            NVSC_HSB_PULSE: begin
                if (st_ff.cnt == '0) begin
                    nxt_st.pins.hw_store_busy_n_oe = 1'b0;
                    nxt_st.st = NVSC_HSB_SENSE;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::SENSE_CYC);
                end
            end
            NVSC_HSB_SENSE: begin
                // Past the busy deadline a still-high pin means no store was needed.
                if (st_ff.cnt == '0) begin
                    if (!hsb_s) begin
                        nxt_st.st = NVSC_HSB_WAIT;
                        nxt_st.step = 3'h0;
                        nxt_st.cnt = nvsc_pkg::CNT_W'(STORE_CYC);
                    end else begin
                        nxt_st.skipped = 1'b1;
                        nxt_st.nv_busy = 1'b0;
                        nxt_st.st = NVSC_IDLE;
                        nxt_st.done = 1'b1;
                        nxt_st.ready = 1'b1;
                    end
                end
            end
            NVSC_HSB_WAIT: begin
                // Recovery is timed from the pin's release, also after a supply-loss pull that stored nothing.
                if (hsb_s) begin
                    nxt_st.st = NVSC_RECOVER;
                    nxt_st.cnt = nvsc_pkg::CNT_W'(nvsc_pkg::RECOVER_CYC);
                    nxt_st.dirty = 1'b0;
                end
            end
            NVSC_RECOVER: begin
                if (st_ff.cnt == '0) begin
                    nxt_st.nv_busy = 1'b0;
                    nxt_st.st = NVSC_IDLE;
                    nxt_st.done = (st_ff.step != 3'h7);
                    nxt_st.ready = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff <= RESET_STATE;
            st_ff.cnt <= nvsc_pkg::CNT_W'(RESTORE_CYC);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign req_ready = st_ff.ready;
    assign done = st_ff.done;
    assign rdata = st_ff.rdata;
    assign nv_busy = st_ff.nv_busy;
    assign dirty = st_ff.dirty;
    assign store_skipped = st_ff.skipped;
    assign pins_out = st_ff.pins;

endmodule

// ==== tb/nvsc_host_chk.sv ====
// Checker for the pin and request behaviour of the host-side store/recall controller.
`timescale 1ns/100ps
module nvsc_host_chk #(
    parameter int STORE_CYC = nvsc_pkg::STORE_CYC,
    parameter int RESTORE_CYC = nvsc_pkg::RESTORE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire nvsc_pkg::nvsc_req_type req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [nvsc_pkg::DATA_W-1:0] rdata,
    input wire logic nv_busy,
    input wire logic dirty,
    input wire logic store_skipped,
    input wire nvsc_pkg::nvsc_pins_out_type pins_out,
    input wire nvsc_pkg::nvsc_pins_in_type pins_in
);
    // ----------------------------------------------------------------
    // Pin discipline
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic take;
    assign take = req_valid && req_ready;
    read_start_a: assert property (
        take && req.op == nvsc_pkg::NVSC_OP_READ |=> pins_out.address_in == $past(req.addr)
        ##0 (!pins_out.ce_n && !pins_out.oe_n && pins_out.we_n)[*6] ##1 (done && pins_out.ce_n))
        else $error("read cycle malformed");
    write_cycle_a: assert property (
        take && req.op == nvsc_pkg::NVSC_OP_WRITE |=> (!pins_out.ce_n && !pins_out.we_n && pins_out.data_oe
        && pins_out.data_o == $past(req.wdata) && pins_out.address_in == $past(req.addr))
        ##1 (pins_out.we_n && $stable(pins_out.address_in) && pins_out.data_oe) ##1 (done && dirty))
        else $error("write cycle malformed");
    write_oe_a: assert property (!pins_out.we_n |-> pins_out.oe_n && pins_out.data_oe)
        else $error("output enable low during write");
    hsb_pulse_a: assert property (
        take && req.op == nvsc_pkg::NVSC_OP_HW_STORE |=> pins_out.hw_store_busy_n_oe ##1 !pins_out.hw_store_busy_n_oe)
        else $error("store request pulse wrong");
    seq_clock_a: assert property (
        $fell(pins_out.ce_n) && nv_busy |=> $rose(pins_out.ce_n) && pins_out.we_n && pins_out.oe_n)
        else $error("sequence read malformed");
    seq_order_a: assert property (
        $fell(pins_out.ce_n) && nv_busy && pins_out.address_in == 15'h0e38
        |-> ##2 ($fell(pins_out.ce_n) && pins_out.address_in == 15'h31c7)
        ##2 ($fell(pins_out.ce_n) && pins_out.address_in == 15'h03e0)
        ##2 ($fell(pins_out.ce_n) && pins_out.address_in == 15'h3c1f)
        ##2 ($fell(pins_out.ce_n) && pins_out.address_in == 15'h303f)
        ##2 ($fell(pins_out.ce_n) && (pins_out.address_in == 15'h0fc0 || pins_out.address_in == 15'h0c63)))
        else $error("sequence order wrong");
    busy_write_a: assert property (nv_busy |-> pins_out.we_n && !pins_out.data_oe)
        else $error("write while nonvolatile cycle runs");
    recover_wait_a: assert property (
        $rose(pins_in.hw_store_busy_n_i) && nv_busy |-> pins_out.ce_n[*8])
        else $error("access too soon after store");
    recall_c: cover property (take && req.op == nvsc_pkg::NVSC_OP_SW_RECALL);
    skip_c: cover property ($rose(store_skipped));
    auto_c: cover property (req_ready && $fell(pins_in.hw_store_busy_n_i));
endmodule

bind nvsc_host nvsc_host_chk #(.STORE_CYC(STORE_CYC), .RESTORE_CYC(RESTORE_CYC)) nvsc_host_chk_i (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
    .rdata(rdata), .nv_busy(nv_busy), .dirty(dirty), .store_skipped(store_skipped), .pins_out(pins_out),
    .pins_in(pins_in));

// ==== tb/nvsc_dev_model.sv ====
// Behavioural model of the nonvolatile static memory as seen at its pins.
`timescale 1ns/100ps
module nvsc_dev_model #(
    parameter int STORE_NS = 2000,
    parameter int RECALL_NS = 15000,
    parameter int RESTORE_NS = 800
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [14:0] address_in,
    input wire logic [7:0] data_in,
    input wire logic hw_store_busy_n,
    input wire logic capacitor_supply,
    output logic [7:0] data_q,
    output logic data_en,
    output logic hsb_pull,
    output int stores
);
    // ----------------------------------------------------------------
    // Array, shadow copy and sequence state
    // ----------------------------------------------------------------
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] seq [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic dirty = 1'b0;
    logic inh = 1'b1;
    logic busy = 1'b0;
    logic wr_arm = 1'b0;
    int step = 0;

    task automatic nv_store(input logic forced, input int wait_ns);
        busy = 1'b1;
        hsb_pull = 1'b1;
        #(wait_ns);
        inh = 1'b1;
        if (dirty || forced) begin
            #(STORE_NS);
            nv = mem;
            dirty = 1'b0;
            stores = stores + 1;
        end
        hsb_pull = 1'b0;
        wait (hw_store_busy_n === 1'b1);
        #700 inh = 1'b0;
        busy = 1'b0;
    endtask

    initial begin
        hsb_pull = 1'b0;
        stores = 0;
        #(RESTORE_NS) inh = 1'b0;
    end
    assign data_en = !ce_n && !oe_n && we_n && hw_store_busy_n && !inh;
    assign data_q = mem[address_in];
    always @(ce_n, we_n) begin
        if (wr_arm && (ce_n || we_n)) begin
            mem[address_in] = data_in;
            dirty = 1'b1;
        end
        wr_arm = !ce_n && !we_n && hw_store_busy_n && !inh;
        if (wr_arm) step = 0;
    end
    always @(negedge ce_n) begin
        if (!we_n || inh) begin
            step = 0;
        end else if (step == 5 && address_in[13:0] == 14'h0fc0) begin
            step = 0;
            nv_store(1'b1, 0);
        end else if (step == 5 && address_in[13:0] == 14'h0c63) begin
            step = 0;
            inh = 1'b1;
            #(RECALL_NS);
            mem = nv;
            dirty = 1'b0;
            inh = 1'b0;
        end else if (step < 5 && address_in[13:0] == seq[step]) begin
            step = step + 1;
        end else begin
            step = (address_in[13:0] == seq[0]) ? 1 : 0;
        end
    end
    // Our own pull also makes a falling edge, so busy keeps it from counting as a request.
    always @(negedge hw_store_busy_n) begin
        if (!busy) begin
            #20;
            if (dirty) nv_store(1'b0, 980);
        end
    end
    always @(negedge capacitor_supply) begin
        #100;
        nv_store(1'b0, 1000);
    end
endmodule

// ==== tb/nvsc_host_tb_top.sv ====
// Self-checking testbench for the host-side store/recall controller.
`timescale 1ns/100ps
module nvsc_host_tb_top;
    logic clk_sys;
    logic rst;
    logic req_valid;
    nvsc_pkg::nvsc_req_type req;
    logic req_ready;
    logic done;
    logic [7:0] rdata;
    logic nv_busy;
    logic dirty;
    logic store_skipped;
    nvsc_pkg::nvsc_pins_out_type po;
    nvsc_pkg::nvsc_pins_in_type pin;
    logic [7:0] dev_q;
    logic [7:0] last_d = 8'h00;
    logic dev_en;
    logic dev_pull;
    logic capacitor_supply;
    wire hw_store_busy_n;
    int stores;
    int fails = 0;
    int total_checks = 0;

    // Pulled-up store/busy line; an undriven data bus shows the inverse of its last value.
    assign hw_store_busy_n = !(po.hw_store_busy_n_oe || dev_pull);
    assign pin = '{data_i: dev_en ? dev_q : (po.data_oe ? po.data_o : ~last_d), hw_store_busy_n_i: hw_store_busy_n};
    always @(posedge clk_sys) begin
        if (dev_en) last_d <= dev_q;
        else if (po.data_oe) last_d <= po.data_o;
    end
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    nvsc_host #(.STORE_CYC(50), .RESTORE_CYC(20)) nvsc_host_i (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
        .rdata(rdata), .nv_busy(nv_busy), .dirty(dirty), .store_skipped(store_skipped), .pins_out(po),
        .pins_in(pin));
    nvsc_dev_model nvsc_dev_model_i (
        .ce_n(po.ce_n), .oe_n(po.oe_n), .we_n(po.we_n), .address_in(po.address_in), .data_in(pin.data_i),
        .hw_store_busy_n(hw_store_busy_n), .capacitor_supply(capacitor_supply), .data_q(dev_q), .data_en(dev_en), .hsb_pull(dev_pull),
        .stores(stores));

    task automatic ck(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic op(input nvsc_pkg::nvsc_op_type kind, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: kind, addr: a, wdata: d};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (done !== 1'b1 && n < 2000);
        ck("done", 16'h1, 16'(done));
    endtask

    task automatic t_power;
        int n;
        n = 0;
        ck("reset busy", 16'h1, 16'(nv_busy));
        while (req_ready !== 1'b1 && n < 1000) begin
            @(posedge clk_sys);
            #1 n++;
        end
        ck("restore wait", 16'h1, 16'(n >= 20));
        ck("idle busy", 16'h0, 16'(nv_busy));
        $display("power-up test done");
    endtask

    task automatic t_hw(input logic wr);
        int s0;
        s0 = stores;
        op(nvsc_pkg::NVSC_OP_HW_STORE, 15'h0000, 8'h00);
        ck("store_skipped", 16'(!wr), 16'(store_skipped));
        ck("store count", 16'(s0 + wr), 16'(stores));
        ck("dirty", 16'h0, 16'(dirty));
        op(nvsc_pkg::NVSC_OP_READ, 15'h7fff, 8'h00);
        if (wr) ck("data kept", 16'h00a5, 16'(rdata));
        $display("hardware store test done");
    endtask

    task automatic t_rw;
        op(nvsc_pkg::NVSC_OP_WRITE, 15'h7fff, 8'ha5);
        op(nvsc_pkg::NVSC_OP_WRITE, 15'h0000, 8'h5a);
        op(nvsc_pkg::NVSC_OP_READ, 15'h7fff, 8'h00);
        ck("rdata top", 16'h00a5, 16'(rdata));
        op(nvsc_pkg::NVSC_OP_READ, 15'h0000, 8'h00);
        ck("rdata bottom", 16'h005a, 16'(rdata));
        ck("dirty", 16'h1, 16'(dirty));
        $display("read write test done");
    endtask

    task automatic t_sw;
        int s0;
        op(nvsc_pkg::NVSC_OP_WRITE, 15'h1234, 8'h11);
        s0 = stores;
        op(nvsc_pkg::NVSC_OP_SW_STORE, 15'h0000, 8'h00);
        op(nvsc_pkg::NVSC_OP_SW_STORE, 15'h0000, 8'h00);
        ck("software stores", 16'(s0 + 2), 16'(stores));
        op(nvsc_pkg::NVSC_OP_WRITE, 15'h1234, 8'h22);
        op(nvsc_pkg::NVSC_OP_SW_RECALL, 15'h0000, 8'h00);
        op(nvsc_pkg::NVSC_OP_READ, 15'h1234, 8'h00);
        ck("recalled data", 16'h0011, 16'(rdata));
        ck("dirty", 16'h0, 16'(dirty));
        $display("software store recall test done");
    endtask

    task automatic t_auto(input logic wr);
        int s0;
        int n;
        int dn;
        n = 0;
        dn = 0;
        if (wr) op(nvsc_pkg::NVSC_OP_WRITE, 15'h0042, 8'h3c);
        s0 = stores;
        @(posedge clk_sys);
        capacitor_supply <= 1'b0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (nv_busy !== 1'b1 && n < 40);
        ck("auto busy", 16'h1, 16'(nv_busy));
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            #1 n++;
            dn = dn + (done === 1'b1);
        end
        @(posedge clk_sys);
        capacitor_supply <= 1'b1;
        ck("auto stores", 16'(s0 + wr), 16'(stores));
        ck("auto done", 16'h0, 16'(dn + !req_ready));
        $display("automatic store test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        capacitor_supply = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_power();
        t_hw(1'b0);
        t_rw();
        t_hw(1'b1);
        t_sw();
        t_auto(1'b0);
        t_auto(1'b1);
        results();
    end
    // The scenarios need about a thousand cycles; 20000 leaves ample margin.
    initial begin
        #1000000;
        fails++;
        results();
    end
endmodule
